/* pkg/sprite_pkg.sv */
// Purpose: shared constants for the hardware cursor sprite overlay
// Assumes: 2-bit sprite codes, 32-bit display memory words
// Notes: none
package sprite_pkg;
	localparam int SPRITE_DIM = 64;
	localparam int COORD_W = 12;
	localparam int MEM_ADDR_W = 22;
	localparam int WORDS_PER_ROW = 4;
	localparam int PIX_PER_WORD = 16;
	localparam int SPRITE_BYTES = 1024;
	localparam int BYTES_PER_WORD = 4;
	localparam logic [1:0] CODE_COLOR0 = 2'h0;
	localparam logic [1:0] CODE_COLOR1 = 2'h1;
	localparam logic [1:0] CODE_CLEAR = 2'h2;
	localparam logic [1:0] CODE_INVERT = 2'h3;
	localparam logic [7:0] COLOR0_VALUE = 8'h00;
	localparam logic [7:0] COLOR1_VALUE = 8'hFF;
endpackage

/* logic/sprite_pixel_mix.sv */
// Purpose: combine one sprite code with one display pixel
// Assumes: inputs from the same clock domain
// Notes: registered output, one cycle latency
`timescale 1ns/1ps
module sprite_pixel_mix #(
	parameter int PIX_W = 8
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic active,
	input wire logic [1:0] code,
	input wire logic [PIX_W-1:0] pix_in,
	output logic [PIX_W-1:0] pix_out
);
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pix_out <= '0;
		end else if (!active) begin
			pix_out <= pix_in;
		end else begin
			unique case (code)
				sprite_pkg::CODE_COLOR0: pix_out <= {PIX_W{sprite_pkg::COLOR0_VALUE[0]}};
				sprite_pkg::CODE_COLOR1: pix_out <= {PIX_W{sprite_pkg::COLOR1_VALUE[0]}};
				sprite_pkg::CODE_CLEAR: pix_out <= pix_in;
				sprite_pkg::CODE_INVERT: pix_out <= ~pix_in;
			endcase
		end
	end
endmodule // sprite_pixel_mix

/* logic/sprite_overlay.sv */
// Purpose: hardware cursor sprite fetched from display memory, merged into pixel stream
// Assumes: pixel stream gives a valid strobe with current screen x/y; memory is same clock
// Notes: a row is fetched while the previous scan line's row is shown
`timescale 1ns/1ps
module sprite_overlay #(
	parameter int PIX_W = 8
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic sprite_enable,
	input wire logic window_select,
	input wire logic [sprite_pkg::COORD_W-1:0] sprite_x_position,
	input wire logic [sprite_pkg::COORD_W-1:0] sprite_y_position,
	input wire logic [5:0] sprite_x_offset,
	input wire logic [5:0] sprite_y_offset,
	input wire logic [6:0] sprite_width,
	input wire logic [6:0] sprite_height,
	input wire logic [sprite_pkg::MEM_ADDR_W-1:0] sprite_start_addr,
	input wire logic pix_valid,
	input wire logic line_start,
	input wire logic [sprite_pkg::COORD_W-1:0] screen_x,
	input wire logic [sprite_pkg::COORD_W-1:0] screen_y,
	input wire logic [PIX_W-1:0] pix_in,
	output logic pix_out_valid,
	output logic [PIX_W-1:0] pix_out,
	output logic mem_req,
	output logic [sprite_pkg::MEM_ADDR_W-1:0] mem_addr,
	input wire logic mem_ack,
	input wire logic [31:0] mem_data,
	output logic sprite_active
);
	localparam int ROW_BITS = sprite_pkg::SPRITE_DIM * 2;
	localparam logic [1:0] LAST_WORD = 2'(sprite_pkg::WORDS_PER_ROW - 1);
	localparam logic [6:0] DIM7 = 7'(sprite_pkg::SPRITE_DIM);
	localparam int WORD_BITS = sprite_pkg::PIX_PER_WORD * 2;
	localparam int ROW_BYTES = sprite_pkg::WORDS_PER_ROW * sprite_pkg::BYTES_PER_WORD;

	typedef enum logic [1:0] {FETCH_IDLE, FETCH_REQ, FETCH_WAIT} fetch_type;

	logic rst_a_reg, rst_n;
	fetch_type fetch_reg;
	logic [1:0] word_reg;
	logic [5:0] fetch_row_reg;
	logic [ROW_BITS-1:0] load_row_reg, show_row_reg;
	logic in_rect, mode_on;
	logic [sprite_pkg::COORD_W-1:0] dx, dy, next_dy;
	logic [5:0] col_idx;
	logic [1:0] code_reg;
	logic active_reg;
	logic [PIX_W-1:0] pix_d_reg;
	logic valid_d_reg;
	logic [2:0] ack_count_reg;

	// Reset release through two flops
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rst_a_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_a_reg <= 1'b1;
			rst_n <= rst_a_reg;
		end
	end

	assign mode_on = sprite_enable && !window_select;

	// Clamp visible size so preset plus size never leaves the buffer
	function automatic logic [6:0] clamp_size(input logic [6:0] sz, input logic [5:0] off);
		logic [6:0] room;
		room = DIM7 - {1'b0, off};
		clamp_size = (sz > room) ? room : sz;
	endfunction

	assign dx = screen_x - sprite_x_position;
	assign dy = screen_y - sprite_y_position;
	assign next_dy = screen_y + 1'b1 - sprite_y_position;
	assign in_rect = mode_on && (screen_x >= sprite_x_position) && (screen_y >= sprite_y_position)
		&& (dx < {5'h00, clamp_size(sprite_width, sprite_x_offset)})
		&& (dy < {5'h00, clamp_size(sprite_height, sprite_y_offset)});
	assign col_idx = 6'(dx) + sprite_x_offset;

	// Row fetch for next line, started at a line start when the sprite is on and that next line falls inside it
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			fetch_reg <= FETCH_IDLE;
			word_reg <= 2'h0;
			fetch_row_reg <= 6'h00;
		end else begin
			unique case (fetch_reg)
				FETCH_IDLE: begin
					if (line_start && mode_on && screen_y + 1'b1 >= sprite_y_position
						&& next_dy < {5'h00, clamp_size(sprite_height, sprite_y_offset)}) begin
						fetch_row_reg <= 6'(next_dy) + sprite_y_offset;
						word_reg <= 2'h0;
						fetch_reg <= FETCH_REQ;
					end
				end
				FETCH_REQ: fetch_reg <= FETCH_WAIT;
				FETCH_WAIT: begin
					if (mem_ack) begin
						word_reg <= word_reg + 2'h1;
						fetch_reg <= (word_reg == LAST_WORD) ? FETCH_IDLE : FETCH_REQ;
					end
				end
			endcase
		end
	end

	// Request held until the memory answers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_req <= 1'b0;
		end else begin
			mem_req <= (fetch_reg == FETCH_REQ) || (fetch_reg == FETCH_WAIT && !mem_ack);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_addr <= '0;
		end else if (fetch_reg == FETCH_REQ) begin
			mem_addr <= sprite_start_addr + sprite_pkg::MEM_ADDR_W'(
				({fetch_row_reg, word_reg}) * sprite_pkg::BYTES_PER_WORD);
		end
	end

	// words land in ascending pixel order
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			load_row_reg <= '0;
		end else if (fetch_reg == FETCH_WAIT && mem_ack) begin
			load_row_reg[word_reg*WORD_BITS +: WORD_BITS] <= mem_data;
		end
	end

	// Swap at line start so the shown row never tears mid-line
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			show_row_reg <= '0;
		end else if (line_start) begin
			show_row_reg <= load_row_reg;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			code_reg <= sprite_pkg::CODE_CLEAR;
		end else begin
			code_reg <= show_row_reg[{col_idx, 1'b0} +: 2];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			active_reg <= 1'b0;
		end else begin
			active_reg <= in_rect && pix_valid;
		end
	end

	// Pixel and strobe wait one cycle to line up with the code
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pix_d_reg <= '0;
			valid_d_reg <= 1'b0;
		end else begin
			pix_d_reg <= pix_in;
			valid_d_reg <= pix_valid;
		end
	end

	sprite_pixel_mix #(.PIX_W(PIX_W)) mix_inst (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.active(active_reg),
		.code(code_reg),
		.pix_in(pix_d_reg),
		.pix_out(pix_out)
	);

	// Strobe leaves together with the mixed pixel
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pix_out_valid <= 1'b0;
		end else begin
			pix_out_valid <= valid_d_reg;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sprite_active <= 1'b0;
		end else begin
			sprite_active <= active_reg;
		end
	end

	// Acknowledge count, only for the row length check
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_count_reg <= 3'h0;
		end else if (fetch_reg == FETCH_IDLE) begin
			ack_count_reg <= 3'h0;
		end else if (fetch_reg == FETCH_WAIT && mem_ack) begin
			ack_count_reg <= ack_count_reg + 3'h1;
		end
	end

	// Pixel side checks, plus the fetch address range and word step checks
	a_mode_exclusive: assert property (@(posedge core_clk) disable iff (!rst_n)
		window_select |=> !active_reg)
		else $error("sprite active while window selected");
	a_outside_pass: assert property (@(posedge core_clk) disable iff (!rst_n)
		(pix_valid && !in_rect) |-> ##2 (pix_out == $past(pix_in, 2)))
		else $error("pixel changed outside sprite");
	a_invert_code: assert property (@(posedge core_clk) disable iff (!rst_n)
		(active_reg && code_reg == sprite_pkg::CODE_INVERT) |=> (pix_out == ~$past(pix_d_reg)))
		else $error("invert wrong");
	a_color_one: assert property (@(posedge core_clk) disable iff (!rst_n)
		(active_reg && code_reg == sprite_pkg::CODE_COLOR1) |=> (&pix_out))
		else $error("colour one wrong");
	a_color_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
		(active_reg && code_reg == sprite_pkg::CODE_COLOR0) |=> (pix_out == '0))
		else $error("colour zero wrong");
	a_clear_pass: assert property (@(posedge core_clk) disable iff (!rst_n)
		(active_reg && code_reg == sprite_pkg::CODE_CLEAR) |=> (pix_out == $past(pix_d_reg)))
		else $error("transparent wrong");
	a_addr_range: assert property (@(posedge core_clk) disable iff (!rst_n)
		mem_req |-> (mem_addr - sprite_start_addr < sprite_pkg::MEM_ADDR_W'(sprite_pkg::SPRITE_BYTES)))
		else $error("fetch outside sprite area");
	a_word_step: assert property (@(posedge core_clk) disable iff (!rst_n)
		(fetch_reg == FETCH_WAIT && mem_ack && word_reg != LAST_WORD) |=> ##1
		(mem_addr == $past(mem_addr, 2) + sprite_pkg::MEM_ADDR_W'(sprite_pkg::BYTES_PER_WORD)))
		else $error("row words not consecutive");
	a_overlay_on: assert property (@(posedge core_clk) disable iff (!rst_n)
		(pix_valid && in_rect) |-> ##2 sprite_active)
		else $error("sprite not overlaid");
	a_valid_delay: assert property (@(posedge core_clk) disable iff (!rst_n)
		pix_valid |-> ##2 pix_out_valid)
		else $error("pixel strobe lost");
	a_valid_gap: assert property (@(posedge core_clk) disable iff (!rst_n)
		!pix_valid |-> ##2 !pix_out_valid)
		else $error("stray pixel strobe");
	a_disabled_pass: assert property (@(posedge core_clk) disable iff (!rst_n)
		(pix_valid && !sprite_enable) |-> ##2 (pix_out == $past(pix_in, 2) && !sprite_active))
		else $error("pixel changed while sprite off");
	a_window_pass: assert property (@(posedge core_clk) disable iff (!rst_n)
		(pix_valid && window_select) |-> ##2 (pix_out == $past(pix_in, 2)))
		else $error("pixel changed in window mode");
	a_col_inside: assert property (@(posedge core_clk) disable iff (!rst_n)
		in_rect |-> (int'(dx) + int'(sprite_x_offset) < sprite_pkg::SPRITE_DIM))
		else $error("column outside buffer");
	a_row_inside: assert property (@(posedge core_clk) disable iff (!rst_n)
		in_rect |-> (int'(dy) + int'(sprite_y_offset) < sprite_pkg::SPRITE_DIM))
		else $error("row outside buffer");
	a_left_edge: assert property (@(posedge core_clk) disable iff (!rst_n)
		(pix_valid && mode_on && screen_x == sprite_x_position && screen_y == sprite_y_position
		&& sprite_width != 7'h00 && sprite_height != 7'h00) |-> ##2 sprite_active)
		else $error("sprite corner misplaced");

	// Fetch side checks
	a_req_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		(mem_req && !mem_ack) |=> (mem_req && $stable(mem_addr)))
		else $error("request dropped before answer");
	a_req_drop: assert property (@(posedge core_clk) disable iff (!rst_n)
		(mem_req && mem_ack) |=> !mem_req)
		else $error("request kept after answer");
	a_idle_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
		(fetch_reg == FETCH_IDLE) |=> !mem_req)
		else $error("stray fetch request");
	a_row_stride: assert property (@(posedge core_clk) disable iff (!rst_n)
		(fetch_reg == FETCH_REQ) |=> (mem_addr == sprite_start_addr + sprite_pkg::MEM_ADDR_W'(
		int'($past(fetch_row_reg)) * ROW_BYTES + int'($past(word_reg)) * sprite_pkg::BYTES_PER_WORD)))
		else $error("rows not back to back");
	a_row_words: assert property (@(posedge core_clk) disable iff (!rst_n)
		(fetch_reg == FETCH_WAIT && mem_ack && word_reg == LAST_WORD)
		|=> (fetch_reg == FETCH_IDLE && ack_count_reg == 3'(sprite_pkg::WORDS_PER_ROW)))
		else $error("row not four words");
	a_fetch_off: assert property (@(posedge core_clk) disable iff (!rst_n)
		(line_start && window_select && fetch_reg == FETCH_IDLE) |=> (fetch_reg == FETCH_IDLE))
		else $error("sprite fetch in window mode");
endmodule // sprite_overlay

/* verification/sprite_mem_model.sv */
// Purpose: display memory answering sprite word fetches
// Assumes: one request at a time, random wait of 0 to 3 cycles
// Notes: data bus shows inverted junk outside an acknowledge
`timescale 1ns/1ps
module sprite_mem_model (
	input wire logic core_clk,
	input wire logic mem_req,
	input wire logic [21:0] mem_addr,
	output logic mem_ack,
	output logic [31:0] mem_data
);
	int wait_cnt = 0;
	function automatic logic [31:0] word_at(input logic [21:0] a);
		return {10'h2A5, a} * 32'h9E3779B1;
	endfunction
	initial begin
		mem_ack = 1'b0;
		mem_data = 32'h0;
	end
	// Skip the edge after an acknowledge so one request is never answered twice
	always @(posedge core_clk) begin
		if (mem_ack) begin
			mem_ack <= 1'b0;
			mem_data <= ~mem_data;
		end else if (mem_req && wait_cnt > 0) begin
			wait_cnt <= wait_cnt - 1;
		end else if (mem_req) begin
			mem_ack <= 1'b1;
			mem_data <= word_at(mem_addr);
			wait_cnt <= $urandom % 4;
		end
	end
endmodule // sprite_mem_model

/* verification/hardware_cursor_sprite_overlay_test.sv */
// Purpose: random frames through the sprite overlay, pixel by pixel compare
// Assumes: 72 by 72 screen, sprite settings change only between frames
// Notes: first frames are hand-picked corners
`timescale 1ns/1ps
module hardware_cursor_sprite_overlay_test;
	logic core_clk = 0, resetn = 0, en = 0, win = 0, pv = 0, ls = 0;
	logic [11:0] sx = 0, sy = 0;
	logic [7:0] pin = 0, pout;
	logic pov, req, ack, act;
	logic [21:0] addr;
	logic [31:0] md;
	int xp, yp, xo, yo, w, h, st, err_count = 0, checks_done = 0;
	logic [8:0] q[$];
	logic [8:0] e;
	sprite_overlay dut_u (.core_clk(core_clk), .resetn(resetn), .sprite_enable(en),
		.window_select(win), .sprite_x_position(12'(xp)), .sprite_y_position(12'(yp)),
		.sprite_x_offset(6'(xo)), .sprite_y_offset(6'(yo)), .sprite_width(7'(w)),
		.sprite_height(7'(h)), .sprite_start_addr(22'(st)), .pix_valid(pv),
		.line_start(ls), .screen_x(sx), .screen_y(sy), .pix_in(pin),
		.pix_out_valid(pov), .pix_out(pout), .mem_req(req), .mem_addr(addr),
		.mem_ack(ack), .mem_data(md), .sprite_active(act));
	sprite_mem_model mem_u (.core_clk(core_clk), .mem_req(req), .mem_addr(addr),
		.mem_ack(ack), .mem_data(md));
	initial forever #2.5 core_clk = ~core_clk;
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] want);
		checks_done++;
		if (seen !== want) begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, want, seen);
		end
	endtask
	task automatic give_verdict();
		if (err_count == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	function automatic logic [8:0] expect_px(int x, int y, logic [7:0] p);
		int cx, cy, we, he;
		logic [1:0] c;
		we = (w > 64 - xo) ? 64 - xo : w;
		he = (h > 64 - yo) ? 64 - yo : h;
		if (!en || win || x < xp || x >= xp + we || y < yp || y >= yp + he)
			return {1'b0, p};
		cx = xo + x - xp;
		cy = yo + y - yp;
		c = 2'(mem_u.word_at(22'(st + (cy * 4 + cx / 16) * 4)) >> (2 * (cx % 16)));
		case (c)
			2'h0: return {1'b1, sprite_pkg::COLOR0_VALUE};
			2'h1: return {1'b1, sprite_pkg::COLOR1_VALUE};
			2'h2: return {1'b1, p};
			default: return {1'b1, ~p};
		endcase
	endfunction
	always @(posedge core_clk) begin
		#1;
		if (pov === 1'b1) begin
			e = q.pop_front();
			check("pix_out", pout, e[7:0]);
			check("sprite_active", {7'h0, act}, {7'h0, e[8]});
		end
	end
	initial begin
		#400000;
		err_count++;
		give_verdict();
	end
	initial begin
		void'($urandom(27));
		repeat (5) @(posedge core_clk);
		#1 resetn = 1;
		for (int f = 0; f < 6; f++) begin
			repeat (40) @(posedge core_clk);
			#1;
			xp = 1 + $urandom % 40; yp = 1 + $urandom % 40;
			xo = $urandom % 64; yo = $urandom % 64;
			w = 1 + $urandom % 64; h = 1 + $urandom % 64;
			st = ($urandom % 22'h3FFC00) & ~3;
			en = 1; win = $urandom % 2;
			case (f)
				0: begin xo = 63; w = 64; win = 0; end
				1: begin xo = 0; yo = 0; w = 64; h = 64; xp = 4; yp = 1; win = 0; end
				2: en = 0;
				3: win = 1;
				default: ;
			endcase
			for (int y = 0; y < 72; y++) begin
				ls = 1; sy = 12'(y);
				@(posedge core_clk) #1 ls = 0;
				repeat (30) @(posedge core_clk);
				#1;
				for (int x = 0; x < 72; x++) begin
					pv = 1; sx = 12'(x); pin = 8'($urandom);
					q.push_back(expect_px(x, y, pin));
					@(posedge core_clk) #1;
				end
				pv = 0;
				repeat (4) @(posedge core_clk);
				#1;
			end
		end
		repeat (10) @(posedge core_clk);
		check("pending", 8'(q.size()), 8'h00);
		give_verdict();
	end
endmodule // hardware_cursor_sprite_overlay_test
